// >>> dcn_pkg.sv
// What this block does
// - Break enable with master off raises break
// - End enable with transfer off raises end
// - Four enable bits, reset zero, bits 3..0
// - No bus release between read and write
// - Release only at the boundary after write
// - Internal targets run concurrent unless write buffer
// - NMI halts only full-address burst transfers
// - Full address needs both enables set
// - NMI clears master enable in full-address burst mode
// - Finish current item (and the next one if NMI lands in its write half), stop, free bus
package dcn_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] DCN_OFF_IEN   = 8'h00;
  localparam logic [7:0] DCN_OFF_CTRL  = 8'h04;
  localparam logic [7:0] DCN_OFF_STAT  = 8'h08;
  localparam logic [7:0] DCN_OFF_ISTAT = 8'h0C;
  localparam logic [7:0] DCN_OFF_IMASK = 8'h10;

  // ==========================================================
  // Interrupt enable fields
  localparam int DCN_IEN_CH0_END = 0;
  localparam int DCN_IEN_CH0_BRK = 1;
  localparam int DCN_IEN_CH1_END = 2;
  localparam int DCN_IEN_CH1_BRK = 3;
  localparam logic [3:0] DCN_IEN_RST = 4'h0;

  // ==========================================================
  // Channel control fields, per channel nibble
  localparam int DCN_CTRL_TE    = 0;
  localparam int DCN_CTRL_MTE   = 1;
  localparam int DCN_CTRL_BURST = 2;
  localparam int DCN_CTRL_FULL  = 3;
  localparam int DCN_CTRL_CH_W  = 4;
  localparam logic [7:0] DCN_CTRL_RST = 8'h00;

  // ==========================================================
  // Event status bits
  localparam int DCN_EV_W = 6;
  localparam int DCN_EV_END0 = 0;
  localparam int DCN_EV_BRK0 = 1;
  localparam int DCN_EV_END1 = 2;
  localparam int DCN_EV_BRK1 = 3;
  localparam int DCN_EV_NMI0 = 4;
  localparam int DCN_EV_NMI1 = 5;
  localparam logic [5:0] DCN_EV_RST = 6'h00;

  localparam logic [1:0] DCN_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DCN_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {DCN_IDLE, DCN_RD, DCN_WR} dcn_cyc_t;

endpackage

// >>> dcn_cyc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dcn_cyc_if;
  logic go;
  logic ext_req;
  logic conc_ok;
  logic rd;
  logic wr;
  logic busy;
  logic ext_ack;
  modport ctl (output go, output ext_req, output conc_ok,
               input rd, input wr, input busy, input ext_ack);
  modport seq (input go, input ext_req, input conc_ok,
               output rd, output wr, output busy, output ext_ack);
endinterface
`default_nettype wire

// >>> dcn_chan.sv
`timescale 1ns/10ps
`default_nettype none
module dcn_chan
  import dcn_pkg::*;
(
  // Channel settings
  input  wire logic [3:0] ctrl,
  input  wire logic       end_en,
  input  wire logic       brk_en,
  input  wire logic       nmi_req,
  // Derived state
  output logic            end_req,
  output logic            brk_req,
  output logic            allowed,
  output logic            nmi_halt
);
  wire te    = ctrl[DCN_CTRL_TE];
  wire mte   = ctrl[DCN_CTRL_MTE];
  wire burst = ctrl[DCN_CTRL_BURST];
  wire full  = ctrl[DCN_CTRL_FULL];

  assign end_req  = end_en & ~te;
  assign brk_req  = brk_en & ~mte;
  assign allowed  = full ? (te & mte) : te;
  assign nmi_halt = nmi_req & full & burst & mte;
endmodule
`default_nettype wire

// >>> dcn_seq.sv
`timescale 1ns/10ps
`default_nettype none
module dcn_seq
  import dcn_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // Cycle control
  dcn_cyc_if.seq    cyc
);
  dcn_cyc_t state;
  dcn_cyc_t next_state;

  wire at_boundary = (state == DCN_IDLE);
  wire may_release = at_boundary | cyc.conc_ok;
  wire start       = cyc.go & (~cyc.ext_req | cyc.conc_ok);

  assign cyc.ext_ack = cyc.ext_req & may_release;
  assign cyc.rd      = (state == DCN_RD);
  assign cyc.wr      = (state == DCN_WR);
  assign cyc.busy    = (state != DCN_IDLE);

  always_comb begin
    next_state = state;
    unique case (state)
      DCN_IDLE: if (start) next_state = DCN_RD;
      DCN_RD:   next_state = DCN_WR;
      // stop after the item in progress
      DCN_WR:   next_state = start ? DCN_RD : DCN_IDLE;
      default:  next_state = DCN_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) state <= DCN_IDLE;
    else state <= next_state;
  end
endmodule
`default_nettype wire

// >>> dcn_dma_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module dcn_dma_ctrl
  import dcn_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // AXI4-Lite write address
  input  wire logic [7:0] s_axi_awaddr,
  input  wire logic       s_axi_awvalid,
  output logic            s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0] s_axi_wstrb,
  input  wire logic       s_axi_wvalid,
  output logic            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]      s_axi_bresp,
  output logic            s_axi_bvalid,
  input  wire logic       s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0] s_axi_araddr,
  input  wire logic       s_axi_arvalid,
  output logic            s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]     s_axi_rdata,
  output logic [1:0]      s_axi_rresp,
  output logic            s_axi_rvalid,
  input  wire logic       s_axi_rready,
  // Data path status
  input  wire logic [1:0] xfer_pending,
  input  wire logic [1:0] xfer_last,
  input  wire logic       target_internal,
  input  wire logic       wbuf_used,
  // System events
  input  wire logic       nmi_req,
  input  wire logic       bus_release_req,
  input  wire logic       refresh_req,
  // Bus cycle outputs
  output logic            dma_rd,
  output logic            dma_wr,
  output logic            dma_ch,
  output logic            ext_grant,
  output logic            cpu_owns_bus,
  // Interrupt outputs
  output logic [1:0]      end_irq_req,
  output logic [1:0]      brk_irq_req,
  output logic            irq
);

  // ==========================================================
  // Registers
  logic [3:0]          ien;
  logic [7:0]          ctrl;
  logic [DCN_EV_W-1:0] istat;
  logic [DCN_EV_W-1:0] imask;
  logic [1:0]          end_q;
  logic [1:0]          brk_q;
  logic                cur_ch;

  // ==========================================================
  // Channel slices
  logic [1:0] end_c;
  logic [1:0] brk_c;
  logic [1:0] allow_c;
  logic [1:0] halt_c;

  dcn_chan u_ch0 (
    .ctrl     (ctrl[3:0]),
    .end_en   (ien[DCN_IEN_CH0_END]),
    .brk_en   (ien[DCN_IEN_CH0_BRK]),
    .nmi_req  (nmi_req),
    .end_req  (end_c[0]),
    .brk_req  (brk_c[0]),
    .allowed  (allow_c[0]),
    .nmi_halt (halt_c[0])
  );

  dcn_chan u_ch1 (
    .ctrl     (ctrl[7:4]),
    .end_en   (ien[DCN_IEN_CH1_END]),
    .brk_en   (ien[DCN_IEN_CH1_BRK]),
    .nmi_req  (nmi_req),
    .end_req  (end_c[1]),
    .brk_req  (brk_c[1]),
    .allowed  (allow_c[1]),
    .nmi_halt (halt_c[1])
  );

  // ==========================================================
  // Cycle sequencer
  dcn_cyc_if cyc ();

  wire [1:0] ready_c = allow_c & xfer_pending;
  // Channel 0 wins; choice frozen while busy, across back-to-back pairs; idle rests on 0
  wire       pick_ch = ~ready_c[0] & ready_c[1];
  wire       sel_ch  = cyc.busy ? cur_ch : pick_ch;

  assign cyc.go      = cyc.busy ? ready_c[cur_ch] : (|ready_c);
  assign cyc.ext_req = bus_release_req | refresh_req;
  assign cyc.conc_ok = target_internal & ~wbuf_used;

  dcn_seq u_seq (
    .mclk (mclk),
    .nrst (nrst),
    .cyc  (cyc)
  );

  assign dma_rd       = cyc.rd;
  assign dma_wr       = cyc.wr;
  assign dma_ch       = cur_ch;
  assign ext_grant    = cyc.ext_ack;
  // bus goes back to the CPU when idle
  assign cpu_owns_bus = ~cyc.busy;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) cur_ch <= 1'b0;
    else if (!cyc.busy || cyc.wr) cur_ch <= sel_ch;
  end

  // ==========================================================
  // AXI4-Lite write path
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

  wire       do_write = aw_held & w_held & ~s_axi_bvalid;
  wire       wr_hit   = (aw_addr[1:0] == 2'h0);
  wire       wr_lane  = w_strb[0];
  wire       wr_ien   = do_write & wr_lane & (aw_addr == DCN_OFF_IEN);
  wire       wr_ctrl  = do_write & wr_lane & (aw_addr == DCN_OFF_CTRL);
  wire       wr_istat = do_write & wr_lane & (aw_addr == DCN_OFF_ISTAT);
  wire       wr_imask = do_write & wr_lane & (aw_addr == DCN_OFF_IMASK);
  wire       wr_known = wr_hit & ((aw_addr == DCN_OFF_IEN) | (aw_addr == DCN_OFF_CTRL)
                      | (aw_addr == DCN_OFF_STAT) | (aw_addr == DCN_OFF_ISTAT)
                      | (aw_addr == DCN_OFF_IMASK));
  wire [1:0] wr_resp  = wr_known ? DCN_RESP_OKAY : DCN_RESP_SLVERR;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= DCN_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_resp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Enable and control registers
  // four enables, reset to zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) ien <= DCN_IEN_RST;
    else if (wr_ien) ien <= w_data[3:0];
  end

  // Hardware clears beat a same-cycle write so an NMI halt is never undone.
  logic [7:0] next_ctrl;
  always_comb begin
    next_ctrl = wr_ctrl ? w_data[7:0] : ctrl;
    if (halt_c[0]) next_ctrl[DCN_CTRL_MTE] = 1'b0;
    if (halt_c[1]) next_ctrl[DCN_CTRL_CH_W + DCN_CTRL_MTE] = 1'b0;
    // Transfer count exhausted ends the channel
    if (xfer_last[0]) next_ctrl[DCN_CTRL_TE] = 1'b0;
    if (xfer_last[1]) next_ctrl[DCN_CTRL_CH_W + DCN_CTRL_TE] = 1'b0;
  end

  // software rewrite of master enable restarts
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) ctrl <= DCN_CTRL_RST;
    else ctrl <= next_ctrl;
  end

  // ==========================================================
  // Interrupt requests and event status
  // level requests rebuilt each clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      end_q <= 2'h0;
      brk_q <= 2'h0;
    end else begin
      end_q <= end_c;
      brk_q <= brk_c;
    end
  end

  assign end_irq_req = end_q;
  assign brk_irq_req = brk_q;

  wire [DCN_EV_W-1:0] ev_set = {halt_c[1], halt_c[0],
                                brk_c[1] & ~brk_q[1], end_c[1] & ~end_q[1],
                                brk_c[0] & ~brk_q[0], end_c[0] & ~end_q[0]};
  wire [DCN_EV_W-1:0] ev_clr = wr_istat ? w_data[DCN_EV_W-1:0] : DCN_EV_RST;

  // A new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) istat <= DCN_EV_RST;
    else istat <= (istat & ~ev_clr) | ev_set;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) imask <= DCN_EV_RST;
    else if (wr_imask) imask <= w_data[DCN_EV_W-1:0];
  end

  assign irq = |(istat & imask);

  // ==========================================================
  // AXI4-Lite read path
  wire [7:0] stat_v = {cur_ch, cyc.busy, allow_c, brk_q, end_q};
  logic [31:0] rd_mux;
  logic [1:0]  rd_resp;

  always_comb begin
    rd_mux  = 32'h0000_0000;
    rd_resp = DCN_RESP_OKAY;
    unique case (s_axi_araddr)
      DCN_OFF_IEN:   rd_mux = {28'h000_0000, ien};
      DCN_OFF_CTRL:  rd_mux = {24'h00_0000, ctrl};
      DCN_OFF_STAT:  rd_mux = {24'h00_0000, stat_v};
      DCN_OFF_ISTAT: rd_mux = {26'h000_0000, istat};
      DCN_OFF_IMASK: rd_mux = {26'h000_0000, imask};
      default:       rd_resp = DCN_RESP_SLVERR;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= DCN_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_resp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> dcn_dma_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dcn_dma_ctrl_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Observed ports
  input wire logic target_internal,
  input wire logic wbuf_used,
  input wire logic bus_release_req,
  input wire logic refresh_req,
  input wire logic dma_rd,
  input wire logic dma_wr,
  input wire logic ext_grant,
  input wire logic cpu_owns_bus,
  input wire logic irq
);
  // ==========================================
  // Bus cycle ordering
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire ext = bus_release_req | refresh_req;
  wire conc = target_internal & ~wbuf_used;
  a_pair_whole: assert property (dma_rd |=> dma_wr)
    else $error("read half not followed by write");
  a_wr_cause: assert property (dma_wr |-> $past(dma_rd))
    else $error("write half without read half");
  a_rd_single: assert property (dma_rd |=> !dma_rd)
    else $error("read half held too long");
  a_no_mid_rel: assert property ((dma_rd || dma_wr) && !conc |-> !ext_grant)
    else $error("bus released inside a pair");
  a_rel_after_wr: assert property (dma_wr && ext && !conc |=> !dma_rd)
    else $error("pair started over a pending release");
  a_conc_grant: assert property (conc && ext |-> ext_grant)
    else $error("internal target blocked a release");
  a_idle_grant: assert property (cpu_owns_bus |-> ext_grant == ext)
    else $error("idle grant wrong");
  a_bus_owner: assert property (cpu_owns_bus != (dma_rd || dma_wr))
    else $error("bus owner flag wrong");
  cover property (dma_rd ##1 dma_wr ##1 dma_rd);
  cover property (ext_grant && dma_rd);
  cover property ($rose(irq));
endmodule
bind dcn_dma_ctrl dcn_dma_ctrl_checker u_dcn_dma_ctrl_checker (.*);
`default_nettype wire

// >>> dcn_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcn_far_model (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       nrst,
  // Bench control
  input wire logic [1:0] ld,
  input wire logic [3:0] ld_val,
  input wire logic       rel_in,
  // Cycle view
  input wire logic       dma_wr,
  input wire logic       dma_ch,
  // Data path side
  output logic     [1:0] xfer_pending,
  output logic     [1:0] xfer_last,
  output logic           bus_release_req
);
  logic [3:0] cnt [2];
  assign bus_release_req = rel_in;
  for (genvar c = 0; c < 2; c++) begin : g_ch
    // Item in its write half is no longer pending
    assign xfer_pending[c] = cnt[c] > {3'h0, dma_wr && dma_ch == 1'(c)};
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        cnt[c] <= 4'h0;
        xfer_last[c] <= 1'b0;
      end else begin
        xfer_last[c] <= dma_wr && dma_ch == 1'(c) && cnt[c] == 4'h1;
        if (ld[c]) cnt[c] <= ld_val;
        else if (dma_wr && dma_ch == 1'(c)) cnt[c] <= cnt[c] - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
  import dcn_pkg::*;
;
  logic mclk, nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF, ld_val = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rel_in = 1'b0;
  logic target_internal = 1'b0, wbuf_used = 1'b0, nmi_req = 1'b0, refresh_req = 1'b0;
  logic [1:0] ld = 2'b00, resp;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp, xfer_pending, xfer_last;
  wire logic [1:0] end_irq_req, brk_irq_req;
  wire logic [31:0] s_axi_rdata;
  wire logic bus_release_req, dma_rd, dma_wr, dma_ch, ext_grant, cpu_owns_bus, irq;
  int n_mismatch = 0, num_checks = 0, n_wr = 0;
  dcn_dma_ctrl u_dcn_dma_ctrl (.*);
  dcn_far_model u_dcn_far_model (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (dma_wr === 1'b1) n_wr++;
  // ==========================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(n, e, s_axi_rdata);
  endtask
  task automatic load(input int c, input logic [3:0] n);
    @(posedge mclk);
    ld_val <= n;
    ld[c] <= 1'b1;
    @(posedge mclk);
    ld[c] <= 1'b0;
  endtask
  task automatic pulse_nmi;
    @(posedge mclk);
    nmi_req <= 1'b1;
    @(posedge mclk);
    nmi_req <= 1'b0;
  endtask
  task automatic drain;
    int k;
    k = 0;
    while ((xfer_pending !== 2'b00 || cpu_owns_bus !== 1'b1) && k < 300) begin
      tk(1);
      k++;
    end
    chk("drain", 32'h0, 32'(k == 300));
    @(posedge mclk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    logic [7:0] offs [5];
    offs = '{DCN_OFF_IEN, DCN_OFF_CTRL, DCN_OFF_STAT, DCN_OFF_ISTAT, DCN_OFF_IMASK};
    foreach (offs[i]) rc(offs[i], 32'h0, "reset");
    rc(8'h14, 32'h0, "unmapped");
    chk("slverr", 32'(DCN_RESP_SLVERR), 32'(resp));
    wr(8'h14, 32'h1);
    chk("wr_slverr", 32'(DCN_RESP_SLVERR), 32'(resp));
    wr(DCN_OFF_IEN, 32'hFFFFFFFF);
    chk("wr_okay", 32'(DCN_RESP_OKAY), 32'(resp));
    rc(DCN_OFF_IEN, 32'hF, "ien_bits");
    // Leave no request or event behind for the next scenario
    wr(DCN_OFF_IEN, 32'h0);
    wr(DCN_OFF_ISTAT, 32'h3F);
  endtask
  task automatic t_irq;
    for (int c = 0; c < 2; c++) begin
      wr(DCN_OFF_IEN, 32'h1 << (2 * c));
      tk(2);
      chk("end_req", 32'h1, 32'(end_irq_req[c]));
      wr(DCN_OFF_CTRL, 32'h1 << (4 * c));
      tk(2);
      chk("end_cancel", 32'h0, 32'(end_irq_req[c]));
      wr(DCN_OFF_IEN, 32'h2 << (2 * c));
      tk(2);
      chk("brk_req", 32'h1, 32'(brk_irq_req[c]));
      wr(DCN_OFF_CTRL, 32'h3 << (4 * c));
      tk(2);
      chk("brk_cancel", 32'h0, 32'(brk_irq_req[c]));
      wr(DCN_OFF_CTRL, 32'h0);
    end
    rc(DCN_OFF_ISTAT, 32'hF, "istat");
    chk("irq_masked", 32'h0, 32'(irq));
    wr(DCN_OFF_IMASK, 32'h3F);
    tk(1);
    chk("irq_on", 32'h1, 32'(irq));
    wr(DCN_OFF_IEN, 32'h0);
    wr(DCN_OFF_ISTAT, 32'h3F);
    tk(1);
    chk("irq_clear", 32'h0, 32'(irq));
  endtask
  task automatic t_xfer;
    int w;
    w = n_wr;
    load(0, 4'h3);
    wr(DCN_OFF_CTRL, 32'h9);
    tk(6);
    chk("full_no_mte", w, n_wr);
    wr(DCN_OFF_CTRL, 32'hB);
    wr(DCN_OFF_IEN, 32'h1);
    drain;
    chk("items", w + 3, n_wr);
    tk(2);
    chk("end_on_last", 32'h1, 32'(end_irq_req[0]));
    rc(DCN_OFF_CTRL, 32'hA, "te_cleared");
    wr(DCN_OFF_IEN, 32'h0);
  endtask
  task automatic t_nmi;
    int w, w0;
    w0 = n_wr;
    load(1, 4'hF);
    wr(DCN_OFF_CTRL, 32'hF0);
    tk(3);
    chk("chan", 32'h1, 32'(dma_ch));
    pulse_nmi;
    tk(3);
    chk("nmi_bus_free", 32'h1, 32'(cpu_owns_bus));
    w = n_wr;
    rc(DCN_OFF_CTRL, 32'hD0, "mte_cleared");
    chk("halted", w, n_wr);
    rc(DCN_OFF_ISTAT, 32'h21, "nmi_event");
    wr(DCN_OFF_CTRL, 32'hF0);
    rel_in <= 1'b1;
    repeat (4) @(posedge mclk);
    rel_in <= 1'b0;
    drain;
    chk("resumed", w0 + 15, n_wr);
    w0 = n_wr;
    target_internal <= 1'b1;
    load(0, 4'hF);
    wr(DCN_OFF_CTRL, 32'hB);
    rel_in <= 1'b1;
    pulse_nmi;
    rc(DCN_OFF_CTRL, 32'hB, "nmi_no_effect");
    chk("conc_grant", 32'h1, 32'(ext_grant));
    drain;
    chk("concurrent", w0 + 15, n_wr);
    rel_in <= 1'b0;
    target_internal <= 1'b0;
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    t_regs;
    t_irq;
    t_xfer;
    t_nmi;
    complete_run;
  end
  // Generous bound on the whole sequence
  initial begin
    #50000;
    n_mismatch++;
    complete_run;
  end
endmodule
`default_nettype wire
